// *** logic/tmr0c_defs.vh ***
// Timer0 counter core: register offsets, field positions, reset values.
// Assumes byte offsets on a 32-bit APB bus, one register per word.
`ifndef TMR0C_DEFS_VH
`define TMR0C_DEFS_VH
`define TMR0C_OFF_COUNT_LOW   12'h59c
`define TMR0C_OFF_PERIOD_HIGH 12'h59d
`define TMR0C_OFF_CONTROL_0   12'h59e
`define TMR0C_OFF_CONTROL_1   12'h59f
`define TMR0C_IDX_COUNT_LOW   10'h167
`define TMR0C_IDX_PERIOD_HIGH 10'h168
`define TMR0C_IDX_CONTROL_0   10'h169
`define TMR0C_IDX_CONTROL_1   10'h16a
`define TMR0C_IDX_STATUS      10'h16b
`define TMR0C_C0_EN           7
`define TMR0C_C0_OUT          5
`define TMR0C_C0_WIDTH        4
`define TMR0C_C1_UNSYNCED_COUNT_SELECT        4
`define TMR0C_ST_FLAG         0
`define TMR0C_ST_IRQEN        1
`define TMR0C_ST_SLEEP        2
`define TMR0C_RST_LOW         8'h00
`define TMR0C_RST_HIGH        8'hff
`define TMR0C_RST_CTRL        8'h00
`define TMR0C_CS_PIN          3'h0
`define TMR0C_CS_PIN_INV      3'h1
`define TMR0C_CS_SYSDIV4      3'h2
`define TMR0C_CS_OSC_HF       3'h3
`define TMR0C_CS_OSC_LF       3'h4
`define TMR0C_CS_OSC_MF       3'h5
`define TMR0C_SYSDIV          2'h3
`endif

// *** logic/tmr0c_timer0_counter_core.v ***
// Timer0 counter core with APB register access.
// Assumes clock sources arrive as levels synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "tmr0c_defs.vh"

// Overview of operation
// - Counter runs 8-bit or 16-bit by width
// - Counts rising edges of prescaled source clock
// - 8-bit: low byte clears on shadow match
// - Match reloads shadow from period high byte
// - 16-bit: low read latches high byte
// - 16-bit: low write loads buffered high
// - 16-bit counter wraps all-ones to zero
// - Running 16-bit count readable, not writable
// - Sync mode: pclk/4 rate, halts in sleep
// - Unsynced_count_select mode counts prescaler edges in sleep
// - Sixteen hidden prescale ratios 1:1 to 1:32768
// - Prescaler clears on count low and control writes, and reset
// - Sixteen hidden postscale ratios 1:1 to 1:16
// - Postscaler clears on count low and control writes, and reset
// - Output toggles on postscaled match/rollover
// - Output routed out and readable in control 0 bit 5
// - Flag set on toggle; irq when enabled
// - Flag every postscale+1 events
// - Counting clock from clock source select
// - Source codes: pin, inverted, div4, oscillators
// - Width bit 1 = 16-bit, 0 = 8-bit
// - Unsynced_count_select event in sleep wakes if enabled
module tmr0c_timer0_counter_core #(
    parameter PRE_W = 15
) (
    // APB
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Clock sources and power state
    input  wire        ext_clk_pin,
    input  wire        osc_hf,
    input  wire        osc_lf,
    input  wire        osc_mf,
    input  wire        sleep_mode,
    // Timer output and interrupt
    output wire        timer_output,
    output wire        timer_irq,
    output wire        wake_req
);

    reg  [7:0]       count_low_r;
    reg  [7:0]       count_high_r;
    reg  [7:0]       period_high_byte_r;
    reg  [7:0]       shadow_r;
    reg  [7:0]       ctrl0_r;
    reg  [7:0]       ctrl1_r;
    reg              timer_event_flag_r;
    reg              timer_irq_enable_r;
    reg  [PRE_W-1:0] pre_cnt_r;
    reg  [3:0]       post_cnt_r;
    reg              out_r;
    reg              src_d_r;
    reg              pre_d_r;
    reg  [1:0]       div4_r;
    reg  [31:0]      prdata_r;
    reg              src_sel;
    reg              pre_out;
    reg  [31:0]      rd_nxt;
    reg              wait_r;

    wire       acc    = psel & penable;
    // Writes and read side effects land only at the edge pready is high
    wire       wr     = acc & wait_r & pwrite;
    wire       rd     = acc & wait_r & ~pwrite;
    // Read data is captured one cycle early so it stands with pready
    wire       rd_cap = acc & ~wait_r & ~pwrite;
    wire [9:0] idx    = paddr[11:2];
    wire       en     = ctrl0_r[`TMR0C_C0_EN];
    wire       width_select = ctrl0_r[`TMR0C_C0_WIDTH];
    wire [3:0] postscale_select = ctrl0_r[3:0];
    wire [2:0] clk_source = ctrl1_r[7:5];
    wire       unsynced_count_select = ctrl1_r[`TMR0C_C1_UNSYNCED_COUNT_SELECT];
    wire [3:0] prescale_select = ctrl1_r[3:0];

    // Byte offsets 0x59c..0x59f share one word, so registers decode by word index, one per word
    function is_reg;
        input [9:0] a;
        input [9:0] want;
        begin
            is_reg = (a == want);
        end
    endfunction

    wire wr_low  = wr & is_reg(idx, `TMR0C_IDX_COUNT_LOW);
    wire wr_high = wr & is_reg(idx, `TMR0C_IDX_PERIOD_HIGH);
    wire wr_c0   = wr & is_reg(idx, `TMR0C_IDX_CONTROL_0);
    wire wr_c1   = wr & is_reg(idx, `TMR0C_IDX_CONTROL_1);
    wire wr_st   = wr & is_reg(idx, `TMR0C_IDX_STATUS);
    wire rd_low  = rd & is_reg(idx, `TMR0C_IDX_COUNT_LOW);
    wire scaler_clr = wr_low | wr_c0 | wr_c1;

    // Source mux; reserved codes hold the source low
    always @* begin
        case (clk_source)
            `TMR0C_CS_PIN:     src_sel = ext_clk_pin;
            `TMR0C_CS_PIN_INV: src_sel = ~ext_clk_pin;
            `TMR0C_CS_SYSDIV4: src_sel = div4_r[1];
            `TMR0C_CS_OSC_HF:  src_sel = osc_hf;
            `TMR0C_CS_OSC_LF:  src_sel = osc_lf;
            `TMR0C_CS_OSC_MF:  src_sel = osc_mf;
            default:           src_sel = 1'b0;
        endcase
    end

    wire src_rise = src_sel & ~src_d_r;

    // Prescaler output: bit (field-1) of counter; field 0 passes source
    always @* begin
        if (prescale_select == 4'h0) begin
            pre_out = src_sel;
        end else begin
            pre_out = pre_cnt_r[prescale_select - 4'h1];
        end
    end

    wire pre_rise = pre_out & ~pre_d_r;
    // Sync path is gated to pclk/4 phase and stops in sleep; unsynced_count_select does not
    wire sync_ok = (div4_r == `TMR0C_SYSDIV) & ~sleep_mode;
    wire tick = en & pre_rise & (unsynced_count_select | sync_ok);

    // 8-bit match against shadow, or 16-bit rollover
    wire match8 = ~width_select & (count_low_r == shadow_r);
    wire roll16 = width_select & (&{count_high_r, count_low_r});
    wire event_in = tick & (match8 | roll16);
    wire post_hit = event_in & (post_cnt_r == postscale_select);

    // Source edges are counted every cycle; a prescaler edge is held while sync gating is closed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div4_r  <= 2'h0;
            src_d_r <= 1'b0;
            pre_d_r <= 1'b0;
            pre_cnt_r <= {PRE_W{1'b0}};
        end else begin
            div4_r  <= div4_r + 2'h1;
            src_d_r <= src_sel;
            if (unsynced_count_select | sync_ok) begin
                pre_d_r <= pre_out;
            end
            if (scaler_clr) begin
                pre_cnt_r <= {PRE_W{1'b0}};
            end else if (en & src_rise) begin
                pre_cnt_r <= pre_cnt_r + {{(PRE_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Counter, shadow and postscaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_r  <= `TMR0C_RST_LOW;
            count_high_r <= `TMR0C_RST_LOW;
            shadow_r     <= `TMR0C_RST_HIGH;
            post_cnt_r   <= 4'h0;
            out_r        <= 1'b0;
        end else begin
            if (wr_low && !(en && width_select)) begin
                count_low_r <= pwdata[7:0];
                if (width_select) begin
                    count_high_r <= period_high_byte_r;
                end
            end else if (tick) begin
                if (match8) begin
                    count_low_r <= 8'h00;
                    shadow_r    <= period_high_byte_r;
                end else begin
                    {count_high_r, count_low_r} <= width_select ?
                        {count_high_r, count_low_r} + 16'h0001 :
                        {count_high_r, count_low_r + 8'h01};
                end
            end
            if (scaler_clr) begin
                post_cnt_r <= 4'h0;
            end else if (post_hit) begin
                post_cnt_r <= 4'h0;
            end else if (event_in) begin
                post_cnt_r <= post_cnt_r + 4'h1;
            end
            if (post_hit) begin
                out_r <= ~out_r;
            end
        end
    end

    // Registers; flag set beats a software clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_high_byte_r <= `TMR0C_RST_HIGH;
            ctrl0_r            <= `TMR0C_RST_CTRL;
            ctrl1_r            <= `TMR0C_RST_CTRL;
            timer_event_flag_r <= 1'b0;
            timer_irq_enable_r <= 1'b0;
            prdata_r           <= 32'h0;
        end else begin
            if (rd_low && width_select) begin
                period_high_byte_r <= count_high_r;
            end else if (wr_high) begin
                period_high_byte_r <= pwdata[7:0];
            end
            if (wr_c0) begin
                ctrl0_r <= {pwdata[7], 1'b0, 1'b0, pwdata[4:0]};
            end
            if (wr_c1) begin
                ctrl1_r <= pwdata[7:0];
            end
            if (wr_st) begin
                timer_irq_enable_r <= pwdata[`TMR0C_ST_IRQEN];
            end
            if (post_hit) begin
                timer_event_flag_r <= 1'b1;
            end else if (wr_st && !pwdata[`TMR0C_ST_FLAG]) begin
                timer_event_flag_r <= 1'b0;
            end
            if (rd_cap) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // Read mux
    always @* begin
        rd_nxt = 32'h0;
        case (idx)
            `TMR0C_IDX_COUNT_LOW:   rd_nxt[7:0] = count_low_r;
            `TMR0C_IDX_PERIOD_HIGH: rd_nxt[7:0] = period_high_byte_r;
            `TMR0C_IDX_CONTROL_0:   rd_nxt[7:0] =
                {ctrl0_r[7:6], out_r, ctrl0_r[4:0]};
            `TMR0C_IDX_CONTROL_1:   rd_nxt[7:0] = ctrl1_r;
            `TMR0C_IDX_STATUS:      rd_nxt[2:0] =
                {sleep_mode, timer_irq_enable_r, timer_event_flag_r};
            default:                rd_nxt = 32'h0;
        endcase
    end

    // One wait state keeps read data registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= acc & ~wait_r;
        end
    end

    wire mapped = (idx >= `TMR0C_IDX_COUNT_LOW) && (idx <= `TMR0C_IDX_STATUS);
    assign pready  = wait_r;
    assign pslverr = wait_r & ~mapped;
    assign prdata  = prdata_r;
    assign timer_output = out_r;
    assign timer_irq = timer_event_flag_r & timer_irq_enable_r;
    assign wake_req = timer_irq & sleep_mode & unsynced_count_select;

endmodule
`default_nettype wire

// *** dv/tmr0c_checker_assertions.sv ***
// Checker: APB handshake and output relations of the timer core.
// Assumes a master that holds each request until pready.
`timescale 1ns/1ps
`default_nettype none
`include "tmr0c_defs.vh"
module tmr0c_checker (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer side
    input wire logic        sleep_mode,
    input wire logic        timer_output,
    input wire logic        timer_irq,
    input wire logic        wake_req
);
    wire logic ok = paddr[11:2] >= `TMR0C_IDX_COUNT_LOW &&
                    paddr[11:2] <= `TMR0C_IDX_STATUS;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wait_state_a: assert property (psel && !penable |=> !pready)
        else $error("pready in first access cycle");
    answer_due_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    unmapped_err_a: assert property (pready && !ok |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (pready && ok |-> !pslverr)
        else $error("mapped access flagged as error");
    rdata_hold_a: assert property (!(psel && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    wake_cause_a: assert property (wake_req |-> timer_irq && sleep_mode)
        else $error("wake request without cause");
    toggle_gap_a: assert property ($changed(timer_output) |=> $stable(timer_output))
        else $error("output toggled on adjacent cycles");
endmodule

bind tmr0c_timer0_counter_core tmr0c_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode),
    .timer_output(timer_output), .timer_irq(timer_irq), .wake_req(wake_req)
);
`default_nettype wire

// *** dv/timer0_counter_core_test.sv ***
// Bench: APB driver, read scoreboard and toggle interval timing.
// Assumes sources are pclk-synchronous levels made here.
`timescale 1ns/1ps
`default_nettype none
`include "tmr0c_defs.vh"
module timer0_counter_core_test;
    logic        pclk, presetn, psel, penable, pwrite, sleep_mode;
    logic        ext_clk_pin, osc_hf, osc_lf, osc_mf;
    logic [11:0] paddr;
    logic [31:0] pwdata, seed;
    wire  [31:0] prdata;
    wire         pready, pslverr, timer_output, timer_irq, wake_req;
    logic [9:0]  exp_q[$];
    logic [9:0]  e;
    logic [3:0]  pre;
    logic [7:0]  per;
    logic        post;
    int          err_count, comparisons, cyc, n;
    int          sper [6] = '{4, 4, 4, 2, 6, 8};

    tmr0c_timer0_counter_core #(.PRE_W(15)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .osc_hf(osc_hf), .osc_lf(osc_lf), .osc_mf(osc_mf),
        .sleep_mode(sleep_mode), .timer_output(timer_output),
        .timer_irq(timer_irq), .wake_req(wake_req));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Sources of different periods; pin, inverted pin and div4 codes all run at 4 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ext_clk_pin <= (cyc % 4) < 2;
        osc_hf <= ~osc_hf;
        osc_lf <= (cyc % 6) < 3;
        osc_mf <= (cyc % 8) < 4;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    task report_and_stop;
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            err_count++;
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bit 9 of a note means the low data byte is not predictable
    task rd(input logic [9:0] idx, input logic [9:0] note);
        exp_q.push_back(note);
        apb(1'b0, idx, 8'h00);
    endtask

    task wait_tog(input int lim, output int c);
        logic o;
        o = timer_output;
        c = 0;
        while (timer_output === o && c < lim) begin
            @(posedge pclk);
            c++;
        end
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            check({pslverr, (pslverr | e[9]) ? 8'h00 : prdata[7:0]}, e[8:0]);
        end
    end

    initial begin
        {psel, penable, pwrite, presetn, sleep_mode} = 5'h00;
        {ext_clk_pin, osc_hf, osc_lf, osc_mf} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cyc = 0;
        seed = 32'h6920c6a5;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TMR0C_IDX_COUNT_LOW, 10'h000);
        rd(`TMR0C_IDX_PERIOD_HIGH, 10'h0ff);
        rd(`TMR0C_IDX_CONTROL_0, 10'h000);
        rd(`TMR0C_IDX_CONTROL_1, 10'h000);
        rd(10'h16c, 10'h100);
        for (int s = 0; s < 6; s++) begin
            seed = xs(seed);
            per = {5'h0, seed[2:0]};
            pre = {2'b0, seed[5:4]};
            post = seed[8];
            apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h00);
            apb(1'b1, `TMR0C_IDX_PERIOD_HIGH, per);
            apb(1'b1, `TMR0C_IDX_COUNT_LOW, 8'h00);
            apb(1'b1, `TMR0C_IDX_CONTROL_1, {s[2:0], 1'b1, pre});
            apb(1'b1, `TMR0C_IDX_CONTROL_0, {7'h40, post});
            // First interval may still use the old shadow period
            wait_tog(40000, n);
            wait_tog(40000, n);
            check(32'(n), 32'(sper[s] * (per + 1) * (1 << pre) * (post + 1)));
        end
        apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h10);
        apb(1'b1, `TMR0C_IDX_PERIOD_HIGH, 8'h12);
        apb(1'b1, `TMR0C_IDX_COUNT_LOW, 8'h34);
        rd(`TMR0C_IDX_COUNT_LOW, 10'h034);
        rd(`TMR0C_IDX_PERIOD_HIGH, 10'h012);
        apb(1'b1, `TMR0C_IDX_PERIOD_HIGH, 8'hff);
        apb(1'b1, `TMR0C_IDX_COUNT_LOW, 8'hf0);
        apb(1'b1, `TMR0C_IDX_CONTROL_1, 8'h70);
        apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h90);
        wait_tog(200, n);
        check(32'(n > 20 && n < 40), 32'h1);
        // A taken low write would load 0xff into the upper byte
        apb(1'b1, `TMR0C_IDX_COUNT_LOW, 8'h00);
        apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h10);
        rd(`TMR0C_IDX_COUNT_LOW, 10'h200);
        rd(`TMR0C_IDX_PERIOD_HIGH, 10'h000);
        apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h00);
        apb(1'b1, `TMR0C_IDX_PERIOD_HIGH, 8'h03);
        apb(1'b1, `TMR0C_IDX_STATUS, 8'h02);
        sleep_mode <= 1'b1;
        apb(1'b1, `TMR0C_IDX_CONTROL_1, 8'h70);
        apb(1'b1, `TMR0C_IDX_CONTROL_0, 8'h80);
        wait_tog(2000, n);
        repeat (2) @(negedge pclk);
        check({timer_irq, wake_req}, 2'b11);
        rd(`TMR0C_IDX_STATUS, 10'h007);
        apb(1'b1, `TMR0C_IDX_CONTROL_1, 8'h60);
        wait_tog(300, n);
        check(32'(n), 32'd300);
        report_and_stop;
    end
endmodule
`default_nettype wire
